// ### rtl/dpm_pkg.sv
package dpm_pkg;
   // Register offsets on the management register port
   localparam logic [7:0] DPM_OFS_MAP_52_55 = 8'h9d;
   localparam logic [7:0] DPM_OFS_MAP_56_59 = 8'h9e;
   localparam logic [7:0] DPM_OFS_MAP_60_63 = 8'h9f;
   // Lower neighbour of the same layout, four code points per register
   localparam logic [7:0] DPM_OFS_MAP_08_0B = 8'h92;
   // First code point held here, and the first code point of the lower register 0x92
   localparam logic [5:0] DPM_FIRST_CP      = 6'h34;
   localparam logic [5:0] DPM_LOW_CP_8      = 6'h08;
   localparam int         DPM_NUM_REGS      = 3;
   localparam int         DPM_FIELD_W       = 2;
   localparam int         DPM_FIELDS_PER_REG = 4;
   localparam logic [7:0] DPM_RESET_VAL     = 8'h00;
   localparam logic [1:0] DPM_DEFAULT_PRIO  = 2'h0;
   // Code point sits in the upper six bits of the ToS / traffic-class byte
   localparam int         DPM_CP_LSB        = 2;
   localparam int         DPM_CP_MSB        = 7;
   // Classifier ip version codes
   localparam logic       DPM_IPV4          = 1'b0;
   localparam logic       DPM_IPV6          = 1'b1;
endpackage : dpm_pkg

// ### rtl/dpm_field_pick.sv
`timescale 1ns/10ps
module dpm_field_pick
   import dpm_pkg::*;
(
   // Flattened table, code point 0x34 at bits 1-0
   input  wire logic [DPM_NUM_REGS*8-1:0] table_bits,
   // Lookup
   input  wire logic [5:0]                code_point,
   output logic                           hit,
   output logic      [1:0]                prio
);
   logic [5:0] rel;

   always_comb begin
      rel  = code_point - DPM_FIRST_CP;
      hit  = (code_point >= DPM_FIRST_CP);
      prio = DPM_DEFAULT_PRIO;
      if (hit) begin
         // Field sits at twice the relative code point
         prio = table_bits[{rel[3:0], 1'b0} +: DPM_FIELD_W];
      end
   end
endmodule : dpm_field_pick

// ### rtl/dpm_prio_map.sv
// How it works
// - Register 0x9d holds 2-bit priorities for code points 0x34..0x37, lowest at bits 1-0.
// - Register 0x9e holds 2-bit priorities for code points 0x38..0x3b, lowest at bits 1-0.
// - Register 0x9f holds 2-bit priorities for code points 0x3c..0x3f, closing the table.
// - Every field is read/write and resets to 00, so priority zero is the default.
// - IPv4 and IPv6 frames share one table entry per code point.
// - Lower code points use the same layout in earlier registers, e.g. 0x92 for 0x08..0x0b.
`timescale 1ns/10ps
module dpm_prio_map
   import dpm_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Management register port
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic            reg_hit,
   // Classifier request
   input  wire logic       cls_valid,
   input  wire logic       cls_ip_ver,
   input  wire logic [7:0] cls_tos,
   // Classifier answer to the queueing logic
   output logic            prio_valid,
   output logic            prio_hit,
   output logic      [1:0] prio_out
);
   // Code points held here, four to a register
   localparam int NUM_CPS = DPM_NUM_REGS * DPM_FIELDS_PER_REG;

   // Register bank
   logic [7:0]                map_reg         [DPM_NUM_REGS];
   logic [7:0]                next_map_reg    [DPM_NUM_REGS];
   // Bus decode
   logic                      addr_mapped;
   logic [DPM_NUM_REGS-1:0]   wr_sel;
   logic [DPM_NUM_REGS-1:0]   rd_sel;
   logic [7:0]                rd_word;
   // Bus answer
   logic [7:0]                next_reg_rdata;
   logic                      next_reg_hit;
   // Lookup path
   logic [1:0]                cp_prio         [NUM_CPS];
   logic [DPM_NUM_REGS*8-1:0] table_bits;
   logic [5:0]                code_point;
   logic                      pick_hit;
   logic [1:0]                pick_prio;
   logic                      next_prio_valid;
   logic                      next_prio_hit;
   logic [1:0]                next_prio_out;

   // Register index for an offset, or -1 when not ours
   function automatic int reg_index(input logic [7:0] addr);
      unique case (addr)
         DPM_OFS_MAP_52_55: reg_index = 0;
         DPM_OFS_MAP_56_59: reg_index = 1;
         DPM_OFS_MAP_60_63: reg_index = 2;
         default:           reg_index = -1;
      endcase
   endfunction : reg_index

   // True for the three offsets held here
   function automatic logic is_mapped(input logic [7:0] addr);
      is_mapped = (reg_index(addr) >= 0);
   endfunction : is_mapped

   // Offset of the register holding a code point, four per register
   // Kept as arithmetic so this bank cannot drift from the lower registers
   function automatic logic [7:0] cp_reg_offset(input logic [5:0] cp);
      logic [5:0] rel;
      rel           = cp - DPM_LOW_CP_8;
      cp_reg_offset = DPM_OFS_MAP_08_0B + {4'h0, rel[5:2]};
   endfunction : cp_reg_offset

   // Bank slot of a code point, counted from the first register held here
   function automatic int cp_slot(input logic [5:0] cp);
      logic [7:0] ofs;
      ofs     = cp_reg_offset(cp) - DPM_OFS_MAP_52_55;
      cp_slot = int'(ofs);
   endfunction : cp_slot

   // Lowest code point of a register sits at bits 1-0
   function automatic int cp_field_lsb(input logic [5:0] cp);
      cp_field_lsb = DPM_FIELD_W * int'(cp[1:0]);
   endfunction : cp_field_lsb

   // One priority field out of a register byte
   function automatic logic [1:0] field_get(input logic [7:0] word, input int lsb);
      field_get = word[lsb +: DPM_FIELD_W];
   endfunction : field_get

   // Code point is the top six bits of the ToS or traffic-class byte
   function automatic logic [5:0] tos_code_point(input logic [7:0] tos);
      tos_code_point = tos[DPM_CP_MSB:DPM_CP_LSB];
   endfunction : tos_code_point

   // Per code point view of the bank, placed through the shared packing
   // Nothing is stored twice; this view is only wiring
   always_comb begin
      logic [5:0] cp;
      cp = DPM_FIRST_CP;
      for (int j = 0; j < NUM_CPS; j++) begin
         cp         = DPM_FIRST_CP + 6'(j);
         cp_prio[j] = field_get(map_reg[cp_slot(cp)], cp_field_lsb(cp));
      end
   end

   // Flattened in code point order, 0x34 at bits 1-0, for the picker
   always_comb begin
      for (int j = 0; j < NUM_CPS; j++) begin
         table_bits[j*DPM_FIELD_W +: DPM_FIELD_W] = cp_prio[j];
      end
   end

   // A write and a read in one cycle are both taken; the read
   // returns the contents from before the write
   always_comb begin
      addr_mapped = is_mapped(reg_addr);
      wr_sel      = '0;
      rd_sel      = '0;
      for (int i = 0; i < DPM_NUM_REGS; i++) begin
         if (reg_index(reg_addr) == i) begin
            wr_sel[i] = reg_wr;
            rd_sel[i] = reg_rd;
         end
      end
   end

   // Flat and-or read mux; zero unless a mapped register is read
   always_comb begin
      rd_word = 8'h00;
      for (int i = 0; i < DPM_NUM_REGS; i++) begin
         if (rd_sel[i]) begin
            rd_word = rd_word | map_reg[i];
         end
      end
   end

   // Table next value; writes to other offsets leave it alone
   always_comb begin
      for (int i = 0; i < DPM_NUM_REGS; i++) begin
         next_map_reg[i] = map_reg[i];
         if (wr_sel[i]) begin
            next_map_reg[i] = reg_wdata;
         end
      end
   end

   // Answer stands one cycle; reg_rdata is zero when nothing was read
   // and reg_hit is set by a read or a write, so several banks on the management port can be or-ed together
   always_comb begin
      next_reg_hit   = 1'b0;
      next_reg_rdata = 8'h00;
      if (addr_mapped) begin
         next_reg_hit = reg_wr | reg_rd;
         if (reg_rd) begin
            next_reg_rdata = rd_word;
         end
      end
   end

   // Version is not looked at: one entry serves both
   assign code_point = tos_code_point(cls_tos);

   // Range test and field pick relative to the first code point held here
   dpm_field_pick dpm_field_pick_inst (
      .table_bits (table_bits),
      .code_point (code_point),
      .hit        (pick_hit),
      .prio       (pick_prio)
   );

   // A lookup in the cycle of a write sees the old entry; software must
   // let one cycle pass after changing the table
   always_comb begin
      next_prio_valid = cls_valid;
      next_prio_hit   = 1'b0;
      next_prio_out   = DPM_DEFAULT_PRIO;
      if (cls_valid) begin
         next_prio_hit = pick_hit;
         next_prio_out = pick_prio;
      end
   end

   // Table registers
   always_ff @(posedge clk) begin
      for (int i = 0; i < DPM_NUM_REGS; i++) begin
         if (!rst_n) begin
            map_reg[i] <= DPM_RESET_VAL;
         end else begin
            map_reg[i] <= next_map_reg[i];
         end
      end
   end

   // Bus answer registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
         reg_hit   <= 1'b0;
      end else begin
         reg_rdata <= next_reg_rdata;
         reg_hit   <= next_reg_hit;
      end
   end

   // Lookup answer registers
   // One cycle from request to answer; a request may come every cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prio_valid <= 1'b0;
         prio_hit   <= 1'b0;
         prio_out   <= DPM_DEFAULT_PRIO;
      end else begin
         prio_valid <= next_prio_valid;
         prio_hit   <= next_prio_hit;
         prio_out   <= next_prio_out;
      end
   end
endmodule : dpm_prio_map

// ### tb/dpm_prio_map_chk.sv
`timescale 1ns/10ps
module dpm_prio_map_chk
   import dpm_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Management register port
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_hit,
   // Classifier request and answer
   input  wire logic       cls_valid,
   input  wire logic       cls_ip_ver,
   input  wire logic [7:0] cls_tos,
   input  wire logic       prio_valid,
   input  wire logic       prio_hit,
   input  wire logic [1:0] prio_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property wr_rd_p(a);
      reg_wr && reg_addr == a ##1 reg_rd && !reg_wr && reg_addr == a
         |=> reg_hit && reg_rdata == $past(reg_wdata, 2);
   endproperty
   map_low_a: assert property (wr_rd_p(8'h9d)) else $error("bad 9d");
   map_mid_a: assert property (wr_rd_p(8'h9e)) else $error("bad 9e");
   map_top_a: assert property (wr_rd_p(8'h9f)) else $error("bad 9f");
   reset_zero_a: assert property (disable iff (1'b0)
      !rst_n |=> !reg_hit && reg_rdata == 8'h00 && !prio_valid && !prio_hit
      && prio_out == 2'h0) else $error("reset not zero");
   unmapped_rd_a: assert property (reg_rd && !reg_wr
      && !(reg_addr inside {[8'h9d:8'h9f]}) |=> !reg_hit && reg_rdata == 8'h00)
      else $error("unmapped answered");
   upper_hit_a: assert property (cls_valid && cls_tos[7:2] >= 6'h34
      |=> prio_valid && prio_hit) else $error("lookup missed");
   lower_miss_a: assert property (cls_valid && cls_tos[7:2] < 6'h34
      |=> prio_valid && !prio_hit && prio_out == 2'h0) else $error("low hit");
   cover property (reg_wr && reg_addr == 8'h9f);
   cover property (cls_valid && cls_ip_ver);
   cover property (prio_hit && prio_out == 2'h3);
endmodule : dpm_prio_map_chk
bind dpm_prio_map dpm_prio_map_chk dpm_prio_map_chk_inst (.clk(clk), .rst_n(rst_n),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .cls_valid(cls_valid), .cls_ip_ver(cls_ip_ver),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cls_tos(cls_tos),
   .reg_hit(reg_hit), .prio_valid(prio_valid), .prio_hit(prio_hit), .prio_out(prio_out));

// ### tb/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
   $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module tb_top;
   logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, cls_valid = 0, cls_ip_ver = 0;
   logic [7:0]  reg_addr = 0, reg_wdata = 0, cls_tos = 0, reg_rdata;
   logic        reg_hit, prio_valid, prio_hit;
   logic [1:0]  prio_out;
   logic [23:0] tbl = 24'hc61be4;
   int          err_total = 0, check_count = 0;
   always #5 clk = ~clk;
   dpm_prio_map dpm_prio_map_inst (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
      .cls_valid(cls_valid), .cls_ip_ver(cls_ip_ver), .cls_tos(cls_tos),
      .prio_valid(prio_valid), .prio_hit(prio_hit), .prio_out(prio_out));
   // Optional write, then a read in the very next cycle
   task automatic acc(input logic w, input logic [7:0] a, d, e, input logic h);
      @(posedge clk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      if (w) begin
         @(posedge clk);
         reg_wr <= 1'b0;
         reg_rd <= 1'b1;
      end
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 `CHK({reg_hit, reg_rdata}, {h, e})
   endtask : acc
   // Low tos bits are the inverted low code point bits so a wrong slice shows
   task automatic cl(input logic [5:0] cp, input logic v, input logic [2:0] e);
      @(posedge clk);
      cls_valid <= 1'b1;
      cls_tos <= {cp, ~cp[1:0]};
      cls_ip_ver <= v;
      @(posedge clk);
      cls_valid <= 1'b0;
      #1 `CHK({prio_valid, prio_hit, prio_out}, {1'b1, e})
   endtask : cl
   task automatic report_and_stop;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      #5000;
      err_total++;
      report_and_stop();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 3; i++) acc(1'b0, 8'h9d + 8'(i), 8'h00, 8'h00, 1'b1);
      cl(6'h3f, 1'b1, 3'b100);
      acc(1'b1, 8'h9d, tbl[7:0], tbl[7:0], 1'b1);
      acc(1'b1, 8'h9e, tbl[15:8], tbl[15:8], 1'b1);
      acc(1'b1, 8'h9f, tbl[23:16], tbl[23:16], 1'b1);
      acc(1'b1, 8'h92, 8'hff, 8'h00, 1'b0);
      acc(1'b0, 8'ha0, 8'h00, 8'h00, 1'b0);
      cl(6'h08, 1'b0, 3'b000);
      for (int k = 0; k < 24; k++) cl(6'(52 + k % 12), k >= 12, {1'b1, tbl[2*(k%12)+:2]});
      // Reset in mid-run must clear written fields as well
      @(posedge clk) rst_n <= 1'b0;
      @(posedge clk) rst_n <= 1'b1;
      for (int i = 0; i < 3; i++) acc(1'b0, 8'h9d + 8'(i), 8'h00, 8'h00, 1'b1);
      cl(6'h3c, 1'b1, 3'b100);
      report_and_stop();
   end
endmodule : tb_top
